// ---- logic/orm_overrange_flag_clock_out_mux.sv ----
// Contract
// RULE_01: Each of channels A, B and C raises its range flag whenever its input exceeds the range threshold.
// RULE_02: A raised range flag stays high at least the programmed minimum pulse length, even for a short excursion.
// RULE_03: The channel B range flag exists only in four- and two-channel variants and stays low otherwise.
// RULE_04: Only the four-channel variant produces a channel C range flag.
// RULE_05: The channel C pin carries a divided reference clock when the select enables it and synth enable is high.
// RULE_06: With select zero or the clock output disabled by register, the channel C pin carries the channel C flag.
// RULE_07: Select 0x1 gives the undivided reference copy, 0x2 the copy divided by two, 0x3 divided by four.
// RULE_08: The clock appears on channel C from power-up when synth enable is high, power-down low and select nonzero.
// RULE_09: Power-down high stops the reference output and the clock outputs on the channel C and D pins.
// RULE_10: A clock appears on the channel D pin only while a clock is output on the channel C pin.
// RULE_11: A range flag falls only once the input is back within threshold and the minimum pulse count has elapsed.
//
// Added by the designer: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module orm_overrange_flag_clock_out_mux #(
  parameter int NUM_CHAN = 4
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [orm_pkg::NUM_CH_MAX-1:0][orm_pkg::SAMPLE_W-1:0] i_chan_magnitude,
  input wire logic [1:0] i_clock_out_select,
  input wire logic i_synth_en,
  input wire logic i_power_down_pin,
  input wire logic [orm_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [orm_pkg::DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [orm_pkg::DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_range_flag_chan_a,
  output logic o_range_flag_chan_b,
  output logic o_range_flag_chan_c,
  output logic o_range_flag_chan_d,
  output logic o_synth_ref_clock_out,
  output logic o_irq
);
  import orm_pkg::*;

  logic [5:0] ctrl_reg;
  logic [SAMPLE_W-1:0] thresh_reg;
  logic [PULSE_W-1:0] min_pulse_reg;
  logic [NUM_CH_MAX-1:0] irq_stat_reg;
  logic [NUM_CH_MAX-1:0] irq_mask_reg;
  logic [NUM_CH_MAX-1:0] flag_reg;
  logic [NUM_CH_MAX-1:0] flag_prev_reg;
  logic [PULSE_W-1:0] cnt_reg [NUM_CH_MAX];
  logic [1:0] strap_reg;
  logic strap_taken_reg;
  logic wait_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [2:0] div_reg;
  logic out_c_reg;
  logic out_d_reg;
  logic ref_out_reg;
  logic irq_reg;
  logic clk_c_on_reg;
  logic clk_d_on_reg;

  logic [NUM_CH_MAX-1:0] chan_present;
  logic [NUM_CH_MAX-1:0] exceed;
  logic [PULSE_W-1:0] min_eff;
  logic [1:0] sel_c;
  logic [1:0] sel_d;
  logic synth_active;
  logic clk_c_on;
  logic clk_d_on;
  logic bus_take;
  logic wr_take;

  function automatic logic pick_clock(input logic [1:0] sel, input logic [2:0] div);
    unique case (sel)
      CLK_SEL_OFF: pick_clock = 1'b0;
      CLK_SEL_DIV1: pick_clock = div[0];
      CLK_SEL_DIV2: pick_clock = div[1];
      CLK_SEL_DIV4: pick_clock = div[2];
    endcase
  endfunction

  // A zero minimum is treated as one cycle so that every excursion is seen by the host.
  assign min_eff = (min_pulse_reg == '0) ? PULSE_W'(1) : min_pulse_reg;

  // Channel B needs two channels, channels C and D need the four-channel variant.
  assign chan_present[0] = 1'b1;
  assign chan_present[1] = (NUM_CHAN >= 2); // [RULE_03]
  assign chan_present[2] = (NUM_CHAN >= 4); // [RULE_04]
  assign chan_present[3] = (NUM_CHAN >= 4);

  genvar g;
  generate
    for (g = 0; g < NUM_CH_MAX; g++) begin : g_chan
      assign exceed[g] = chan_present[g] && (i_chan_magnitude[g] > thresh_reg); // [RULE_01]

      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          flag_reg[g] <= 1'b0;
          cnt_reg[g] <= '0;
        end else if (exceed[g]) begin
          flag_reg[g] <= 1'b1; // [RULE_01]
          cnt_reg[g] <= min_eff; // [RULE_02]
        end else if (cnt_reg[g] > PULSE_W'(1)) begin
          cnt_reg[g] <= cnt_reg[g] - PULSE_W'(1); // [RULE_02]
        end else begin
          flag_reg[g] <= 1'b0; // [RULE_11]
          cnt_reg[g] <= '0;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      flag_prev_reg <= '0;
    end else begin
      flag_prev_reg <= flag_reg;
    end
  end

  // The strap is caught once, on the first edge after reset release.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      strap_reg <= CLK_SEL_OFF;
      strap_taken_reg <= 1'b0;
    end else if (!strap_taken_reg) begin
      strap_reg <= i_clock_out_select;
      strap_taken_reg <= 1'b1;
    end
  end

  // The register override replaces the strap; with the strap the D pin only offers the undivided copy.
  assign sel_c = ctrl_reg[CTRL_OVR_BIT] ? ctrl_reg[CTRL_SEL_C_LSB +: 2] : strap_reg;
  assign sel_d = ctrl_reg[CTRL_OVR_BIT] ? ctrl_reg[CTRL_SEL_D_LSB +: 2] :
                 ((strap_reg != CLK_SEL_OFF) ? CLK_SEL_DIV1 : CLK_SEL_OFF);
  assign synth_active = i_synth_en && !i_power_down_pin; // [RULE_09]
  assign clk_c_on = synth_active && strap_taken_reg && (sel_c != CLK_SEL_OFF)
                    && !ctrl_reg[CTRL_CLK_DIS_BIT]; // [RULE_05] [RULE_06] [RULE_08]
  assign clk_d_on = clk_c_on && (sel_d != CLK_SEL_OFF); // [RULE_10]

  // The reference copy is a divided version of the core clock, so it can leave through ordinary flops.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_reg <= 3'h0;
    end else if (synth_active) begin
      div_reg <= div_reg + 3'h1;
    end else begin
      div_reg <= 3'h0; // [RULE_09]
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ref_out_reg <= 1'b0;
    end else begin
      ref_out_reg <= synth_active && div_reg[0]; // [RULE_09]
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      out_c_reg <= 1'b0;
      out_d_reg <= 1'b0;
      clk_c_on_reg <= 1'b0;
      clk_d_on_reg <= 1'b0;
    end else begin
      clk_c_on_reg <= clk_c_on;
      clk_d_on_reg <= clk_d_on;
      out_c_reg <= clk_c_on ? pick_clock(sel_c, div_reg) : flag_reg[2]; // [RULE_05] [RULE_06] [RULE_07]
      out_d_reg <= clk_d_on ? pick_clock(sel_d, div_reg) : flag_reg[3]; // [RULE_10]
    end
  end

  // One wait state per access keeps decode and read data fully registered.
  assign bus_take = (i_avs_read || i_avs_write) && !wait_reg;
  assign wr_take = i_avs_write && !wait_reg;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= !((i_avs_read || i_avs_write) && wait_reg);
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_reg <= '0;
    end else if (i_avs_read && wait_reg) begin
      unique case (i_avs_address)
        CTRL_OFFSET: rdata_reg <= DATA_W'(ctrl_reg);
        THRESH_OFFSET: rdata_reg <= DATA_W'(thresh_reg);
        MIN_PULSE_OFFSET: rdata_reg <= DATA_W'(min_pulse_reg);
        STATUS_OFFSET: rdata_reg <= DATA_W'({clk_d_on_reg, clk_c_on_reg, strap_reg, flag_reg});
        IRQ_STAT_OFFSET: rdata_reg <= DATA_W'(irq_stat_reg);
        IRQ_MASK_OFFSET: rdata_reg <= DATA_W'(irq_mask_reg);
        default: rdata_reg <= '0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_reg <= CTRL_RESET;
      thresh_reg <= THRESH_RESET;
      min_pulse_reg <= MIN_PULSE_RESET;
      irq_mask_reg <= '0;
    end else if (wr_take) begin
      if (i_avs_address == CTRL_OFFSET && i_avs_byteenable[0]) begin
        ctrl_reg <= i_avs_writedata[5:0];
      end
      if (i_avs_address == THRESH_OFFSET) begin
        if (i_avs_byteenable[0]) thresh_reg[7:0] <= i_avs_writedata[7:0];
        if (i_avs_byteenable[1]) thresh_reg[11:8] <= i_avs_writedata[11:8];
      end
      if (i_avs_address == MIN_PULSE_OFFSET) begin
        if (i_avs_byteenable[0]) min_pulse_reg[7:0] <= i_avs_writedata[7:0];
        if (i_avs_byteenable[1]) min_pulse_reg[15:8] <= i_avs_writedata[15:8];
      end
      if (i_avs_address == IRQ_MASK_OFFSET && i_avs_byteenable[0]) begin
        irq_mask_reg <= i_avs_writedata[NUM_CH_MAX-1:0];
      end
    end
  end

  // A rising flag in the same cycle as a write-one-to-clear keeps its status bit.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_stat_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_CH_MAX; i++) begin
        if (flag_reg[i] && !flag_prev_reg[i]) begin
          irq_stat_reg[i] <= 1'b1;
        end else if (wr_take && i_avs_address == IRQ_STAT_OFFSET && i_avs_byteenable[0]
                     && i_avs_writedata[i]) begin
          irq_stat_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  assign o_avs_waitrequest = wait_reg;
  assign o_avs_readdata = rdata_reg;
  assign o_range_flag_chan_a = flag_reg[0];
  assign o_range_flag_chan_b = flag_reg[1];
  assign o_range_flag_chan_c = out_c_reg;
  assign o_range_flag_chan_d = out_d_reg;
  assign o_synth_ref_clock_out = ref_out_reg;
  assign o_irq = irq_reg;

  flag_rise_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [RULE_01]
    (i_chan_magnitude[0] > thresh_reg) |=> o_range_flag_chan_a)
    else $error("Channel A flag missed an exceedance.");

  min_pulse_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [RULE_02]
    ($rose(flag_reg[0]) && min_eff >= PULSE_W'(3) && $stable(min_pulse_reg)) |-> flag_reg[0] [*3])
    else $error("Channel A flag shorter than minimum pulse.");

  chan_b_absent_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [RULE_03]
    (NUM_CHAN < 2) |-> !o_range_flag_chan_b)
    else $error("Channel B flag driven in single-channel variant.");

  chan_c_absent_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [RULE_04]
    ((NUM_CHAN < 4) && !clk_c_on) |=> !o_range_flag_chan_c)
    else $error("Channel C flag driven outside four-channel variant.");

  clock_select_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [RULE_07]
    (clk_c_on && sel_c == CLK_SEL_DIV4) |=> (o_range_flag_chan_c == $past(div_reg[2])))
    else $error("Channel C clock divider mismatch.");

  flag_path_c_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [RULE_06]
    !clk_c_on |=> (o_range_flag_chan_c == $past(flag_reg[2])))
    else $error("Channel C pin not carrying its flag.");

  power_down_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [RULE_09]
    i_power_down_pin |=> (!o_synth_ref_clock_out && !clk_c_on_reg && !clk_d_on_reg))
    else $error("Clock still running under power down.");

  d_needs_c_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [RULE_10]
    clk_d_on_reg |-> clk_c_on_reg)
    else $error("Channel D clock without channel C clock.");

  flag_release_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [RULE_11]
    (flag_reg[0] && cnt_reg[0] > PULSE_W'(1)) |=> flag_reg[0])
    else $error("Channel A flag dropped before count elapsed.");

  strap_clock_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [RULE_08]
    (strap_taken_reg && !ctrl_reg[CTRL_OVR_BIT] && !ctrl_reg[CTRL_CLK_DIS_BIT] && i_synth_en
     && !i_power_down_pin && strap_reg != CLK_SEL_OFF) |=> clk_c_on_reg)
    else $error("Strap-selected clock did not start.");

  bus_answer_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    ((i_avs_read || i_avs_write) && o_avs_waitrequest) |=> !o_avs_waitrequest)
    else $error("Bus access not answered within one cycle.");

  irq_level_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    |(irq_stat_reg & irq_mask_reg) |=> o_irq)
    else $error("Interrupt not raised for unmasked status.");

  irq_quiet_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    ((irq_stat_reg & irq_mask_reg) == '0) |=> !o_irq)
    else $error("Interrupt raised with no unmasked status.");

  bus_release_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    bus_take |=> o_avs_waitrequest)
    else $error("Wait request not restored after an access.");

  flag_b_rise_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [RULE_01]
    ((NUM_CHAN >= 2) && (i_chan_magnitude[1] > thresh_reg)) |=> o_range_flag_chan_b)
    else $error("Channel B flag missed an exceedance.");

  flag_c_rise_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [RULE_01]
    ((NUM_CHAN >= 4) && (i_chan_magnitude[2] > thresh_reg)) |=> flag_reg[2])
    else $error("Channel C flag missed an exceedance.");

  flag_b_hold_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [RULE_02]
    ($rose(flag_reg[1]) && min_eff >= PULSE_W'(2) && $stable(min_pulse_reg)) |-> flag_reg[1] [*2])
    else $error("Channel B flag shorter than minimum pulse.");

  flag_quiet_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [RULE_11]
    (!flag_reg[0] && !exceed[0]) |=> !flag_reg[0])
    else $error("Channel A flag rose without an exceedance.");

  clock_div1_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [RULE_07]
    (clk_c_on && sel_c == CLK_SEL_DIV1) |=> (o_range_flag_chan_c == $past(div_reg[0])))
    else $error("Channel C undivided copy mismatch.");

  clock_div2_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [RULE_07]
    (clk_c_on && sel_c == CLK_SEL_DIV2) |=> (o_range_flag_chan_c == $past(div_reg[1])))
    else $error("Channel C divide-by-two copy mismatch.");

  clock_disable_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [RULE_06]
    ctrl_reg[CTRL_CLK_DIS_BIT] |=> !clk_c_on_reg)
    else $error("Channel C clock running while disabled by register.");

  ref_stop_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [RULE_09]
    !synth_active |=> (div_reg == 3'h0 && !o_synth_ref_clock_out))
    else $error("Reference divider running while synthesizer inactive.");

  d_flag_path_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [RULE_10]
    !clk_d_on |=> (o_range_flag_chan_d == $past(flag_reg[3])))
    else $error("Channel D pin not carrying its flag.");

  strap_hold_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [RULE_08]
    strap_taken_reg |=> $stable(strap_reg))
    else $error("Clock-out strap changed after capture.");
endmodule
`default_nettype wire

// ---- logic/orm_pkg.sv ----
`default_nettype none
package orm_pkg;
  localparam int SAMPLE_W = 12;
  localparam int PULSE_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_CH_MAX = 4;

  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] THRESH_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] MIN_PULSE_OFFSET = 8'h08;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h0C;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFFSET = 8'h10;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFFSET = 8'h14;

  localparam int CTRL_OVR_BIT = 0;
  localparam int CTRL_SEL_C_LSB = 1;
  localparam int CTRL_SEL_D_LSB = 3;
  localparam int CTRL_CLK_DIS_BIT = 5;
  localparam int STATUS_STRAP_LSB = 4;
  localparam int STATUS_CLK_C_BIT = 6;
  localparam int STATUS_CLK_D_BIT = 7;

  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [SAMPLE_W-1:0] THRESH_RESET = 12'hFFF;
  localparam logic [PULSE_W-1:0] MIN_PULSE_RESET = 16'h0001;

  localparam logic [1:0] CLK_SEL_OFF = 2'h0;
  localparam logic [1:0] CLK_SEL_DIV1 = 2'h1;
  localparam logic [1:0] CLK_SEL_DIV2 = 2'h2;
  localparam logic [1:0] CLK_SEL_DIV4 = 2'h3;
endpackage
`default_nettype wire

// ---- verification/orm_host_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module orm_host_monitor (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_flag,
  output logic o_done,
  output logic [15:0] o_len
);
  logic [15:0] run_reg;

  // The host times every flag pulse, so a hold that is too short or too long shows as a wrong length.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      run_reg <= 16'h0000;
      o_done <= 1'b0;
      o_len <= 16'h0000;
    end else begin
      o_done <= 1'b0;
      if (i_flag) begin
        run_reg <= run_reg + 16'h0001;
      end else if (run_reg != 16'h0000) begin
        o_done <= 1'b1;
        o_len <= run_reg;
        run_reg <= 16'h0000;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verification/test_overrange_flag_clock_out_mux.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_overrange_flag_clock_out_mux;
  import orm_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0][11:0] mag = '0;
  logic [1:0] sel = 2'h0;
  logic synth_en = 1'b1;
  logic pd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [31:0] rdata, q;
  logic wait_req, irq, fa, fb, fc, fd, ref_out, sb, sc, mon_done;
  logic [15:0] mon_len;
  logic [15:0] exp_q[$];
  int failures = 0;
  int checks = 0;
  int seed = 2;
  int rc, rd_cnt, rr;
  int nv[4] = '{0, 1, 3, 5};

  always #10 clk = ~clk;

  orm_overrange_flag_clock_out_mux #(.NUM_CHAN(4)) uut (.i_clk(clk), .i_arst_n(arst_n), .i_chan_magnitude(mag),
    .i_clock_out_select(sel), .i_synth_en(synth_en), .i_power_down_pin(pd), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .o_range_flag_chan_a(fa), .o_range_flag_chan_b(fb),
    .o_range_flag_chan_c(fc), .o_range_flag_chan_d(fd), .o_synth_ref_clock_out(ref_out), .o_irq(irq));

  // The single-channel variant shares every input, so absent flags are seen under the same stimulus.
  orm_overrange_flag_clock_out_mux #(.NUM_CHAN(1)) uut_single (.i_clk(clk), .i_arst_n(arst_n),
    .i_chan_magnitude(mag), .i_clock_out_select(sel), .i_synth_en(synth_en), .i_power_down_pin(pd),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
    .o_avs_readdata(), .o_avs_waitrequest(), .o_range_flag_chan_a(), .o_range_flag_chan_b(sb),
    .o_range_flag_chan_c(sc), .o_range_flag_chan_d(), .o_synth_ref_clock_out(), .o_irq());

  orm_host_monitor host (.i_clk(clk), .i_arst_n(arst_n), .i_flag(fa), .o_done(mon_done), .o_len(mon_len));

  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    checks++;
    if (seen !== expv) begin
      failures++;
      $display("mismatch at %0t: seen 0x%0h expected 0x%0h", $time, seen, expv);
    end
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // An idle edge ahead of each request keeps release and raise out of one time step.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 100);
    if (n >= 100) failures++;
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic excursion(input int ch, input int len);
    repeat (len) begin
      mag[ch] <= 12'h801 | 12'($random(seed) & 32'h7FF);
      @(posedge clk);
    end
    mag[ch] <= 12'($random(seed) & 32'h7FF);
  endtask

  task automatic rises(input int n);
    logic pc, pdd, pr;
    rc = 0;
    rd_cnt = 0;
    rr = 0;
    pc = fc;
    pdd = fd;
    pr = ref_out;
    repeat (n) begin
      @(posedge clk);
      if (fc === 1'b1 && pc === 1'b0) rc++;
      if (fd === 1'b1 && pdd === 1'b0) rd_cnt++;
      if (ref_out === 1'b1 && pr === 1'b0) rr++;
      pc = fc;
      pdd = fd;
      pr = ref_out;
    end
  endtask

  task automatic restart(input logic [1:0] s);
    arst_n <= 1'b0;
    sel <= s;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  always @(posedge clk) begin
    if (mon_done === 1'b1) begin
      chk({16'h0000, mon_len},
          (exp_q.size() > 0) ? {16'h0000, exp_q.pop_front()} : 32'hFFFFFFFF);
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    print_verdict();
  end

  initial begin
    restart(2'h0);
    bus(1'b0, THRESH_OFFSET, 32'h0);
    chk(q, 32'h00000FFF);
    bus(1'b0, MIN_PULSE_OFFSET, 32'h0);
    chk(q, 32'h00000001);
    bus(1'b0, 8'h40, 32'h0);
    chk(q, 32'h00000000);
    rises(32);
    chk(rc, 0);
    chk(rd_cnt, 0);
    bus(1'b1, THRESH_OFFSET, 32'h800);
    mag[0] <= 12'h800;
    repeat (4) @(posedge clk);
    chk(fa, 1'b0);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, MIN_PULSE_OFFSET, nv[i]);
      for (int l = 1; l <= 4; l += 3) begin
        exp_q.push_back(16'(l + ((nv[i] == 0) ? 1 : nv[i]) - 1));
        excursion(0, l);
        repeat (8) @(posedge clk);
      end
    end
    chk(exp_q.size(), 0);
    excursion(1, 1);
    @(posedge clk);
    chk({fb, sb}, 2'b10);
    excursion(2, 1);
    // The C pin is registered behind the internal flag, so it shows the flag one edge later.
    repeat (2) @(posedge clk);
    chk({fc, sc}, 2'b10);
    repeat (8) @(posedge clk);
    chk(irq, 1'b0);
    bus(1'b0, IRQ_STAT_OFFSET, 32'h0);
    chk(q, 32'h00000007);
    bus(1'b1, IRQ_MASK_OFFSET, 32'h1);
    repeat (3) @(posedge clk);
    chk(irq, 1'b1);
    bus(1'b1, IRQ_STAT_OFFSET, 32'hF);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    for (int s = 1; s < 4; s++) begin
      restart(2'(s));
      rises(32);
      chk(rc, 32 >> s);
      chk(rd_cnt, 16);
      chk(rr, 16);
    end
    pd <= 1'b1;
    repeat (4) @(posedge clk);
    rises(32);
    chk({rc[7:0], rd_cnt[7:0], rr[7:0]}, 24'h0);
    pd <= 1'b0;
    synth_en <= 1'b0;
    repeat (4) @(posedge clk);
    rises(32);
    chk({rc[7:0], rd_cnt[7:0]}, 16'h0);
    synth_en <= 1'b1;
    bus(1'b1, THRESH_OFFSET, 32'h800);
    bus(1'b1, CTRL_OFFSET, 32'h20);
    repeat (4) @(posedge clk);
    rises(32);
    chk(rc, 0);
    excursion(2, 1);
    repeat (2) @(posedge clk);
    chk(fc, 1'b1);
    // Register override: C takes the divide-by-two copy and D the divide-by-four copy.
    bus(1'b1, CTRL_OFFSET, 32'h1D);
    repeat (4) @(posedge clk);
    rises(32);
    chk(rc, 8);
    chk(rd_cnt, 4);
    bus(1'b0, STATUS_OFFSET, 32'h0);
    chk(q, 32'h000000F0);
    repeat (4) @(posedge clk);
    print_verdict();
  end
endmodule
`default_nettype wire
